// ---- verilog/gpc_port.sv ----
// One 32-pin port of the general-purpose pin controller
// What this block does
// - 32-pin port; set, clear, toggle writes
// - Level register samples pad, gated by ownership/irq-enable
// - Unowned pin: peripheral drives value and enable
// - Owned pin driven when drive-enable bit set
// - Driven owned pin shows output level bit
// - Function number binary across two select registers
// - Peripheral reaches pin only when not owned
// - Peripheral pull-up if supported, else register
// - Pull-up enable bit switches pull-up
// - Set/clear output writes have same latency
// - Interrupt enable bit enables pin interrupt
// - Mode selects change, rising or falling
// - Detection works in GPIO and peripheral mode
// - Four request lines, groups of eight pins
// - Flags sticky until written zero
// - Interrupts only while bus clock runs
// - Register access needs running clock
// - Peripheral keeps pin with clock stopped
// - Stopped clock halts; state kept
// - Debug halt does not affect operation
// - Glitch filter: irq path, two-edge confirm
// - Four event lines, same trigger condition
`timescale 1ns/1ns
`default_nettype none
module gpc_port (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Peripheral bus register port
  input wire logic [9:0] pb_addr,
  input wire logic [31:0] pb_wdata,
  input wire logic pb_wr,
  input wire logic pb_rd,
  output logic [31:0] pb_rdata,
  // CPU local bus, output level and drive enable only
  input wire logic [9:0] lb_addr,
  input wire logic [31:0] lb_wdata,
  input wire logic lb_wr,
  // Pads
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe,
  output logic [31:0] pad_pullup,
  // Peripheral functions, one 32-bit slice per function number
  input wire logic [3:0][31:0] fn_out,
  input wire logic [3:0][31:0] fn_oe,
  input wire logic [3:0][31:0] fn_pull_ctl,
  input wire logic [3:0][31:0] fn_pull,
  // Interrupt requests and events, one per group of eight
  output logic [3:0] irq_req,
  output logic [3:0] event_line
);

  logic [31:0] own_ff;
  logic [31:0] fsel0_ff;
  logic [31:0] fsel1_ff;
  logic [31:0] drv_ff;
  logic [31:0] out_ff;
  logic [31:0] level_ff;
  logic [31:0] pull_ff;
  logic [31:0] irqen_ff;
  logic [31:0] mode0_ff;
  logic [31:0] mode1_ff;
  logic [31:0] gfilt_ff;
  logic [31:0] flags_ff;
  logic [31:0] even_ff;
  logic [31:0] rdata_ff;
  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;
  logic [31:0] filt_ff;
  logic [31:0] det_prev_ff;
  logic [3:0] irq_ff;
  logic [3:0] event_ff;

  logic [31:0] det;
  logic [31:0] cond;
  logic [31:0] nxt_flags;
  logic [31:0] nxt_out;
  logic [31:0] nxt_drv;
  logic [31:0] nxt_rdata;
  logic [3:0] nxt_irq;
  logic [3:0] nxt_event;
  logic [1:0] pb_kind;
  logic [9:0] pb_base;
  logic [1:0] lb_kind;
  logic [9:0] lb_base;

  assign pb_kind = pb_addr[3:2];
  assign pb_base = {pb_addr[9:4], 4'h0};
  assign lb_kind = lb_addr[3:2];
  assign lb_base = {lb_addr[9:4], 4'h0};

  // Word, set, clear or toggle applied to a register value
  function automatic logic [31:0] apply_acc(
    input logic [31:0] cur,
    input logic [1:0] kind,
    input logic [31:0] wd
  );
    logic [31:0] res;
    res = cur;
    unique case (kind)
      gpc_pkg::ACC_WORD: res = wd;
      gpc_pkg::ACC_SET: res = cur | wd;
      gpc_pkg::ACC_CLR: res = cur & ~wd;
      gpc_pkg::ACC_TGL: res = cur ^ wd;
    endcase
    return res;
  endfunction : apply_acc

  function automatic logic hit(
    input logic wr,
    input logic [9:0] base,
    input logic [9:0] ofs
  );
    return wr && (base == ofs);
  endfunction : hit

  // Plain configuration registers, all with four access kinds
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      own_ff <= gpc_pkg::RST_OWN;
      fsel0_ff <= gpc_pkg::RST_ZERO;
      fsel1_ff <= gpc_pkg::RST_ZERO;
      pull_ff <= gpc_pkg::RST_ZERO;
      irqen_ff <= gpc_pkg::RST_ZERO;
      mode0_ff <= gpc_pkg::RST_ZERO;
      mode1_ff <= gpc_pkg::RST_ZERO;
      gfilt_ff <= gpc_pkg::RST_ZERO;
      even_ff <= gpc_pkg::RST_ZERO;
    end
    else
    begin
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_OWN))
        own_ff <= apply_acc(own_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_FSEL0))
        fsel0_ff <= apply_acc(fsel0_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_FSEL1))
        fsel1_ff <= apply_acc(fsel1_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_PULL))
        pull_ff <= apply_acc(pull_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_IRQEN))
        irqen_ff <= apply_acc(irqen_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_MODE0))
        mode0_ff <= apply_acc(mode0_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_MODE1))
        mode1_ff <= apply_acc(mode1_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_GFILT))
        gfilt_ff <= apply_acc(gfilt_ff, pb_kind, pb_wdata);
      if (hit(pb_wr, pb_base, gpc_pkg::OFS_EVEN))
        even_ff <= apply_acc(even_ff, pb_kind, pb_wdata);
    end
  end

  // Output level and drive enable: peripheral bus first, local bus last
  always_comb
  begin
    nxt_out = out_ff;
    nxt_drv = drv_ff;
    if (hit(pb_wr, pb_base, gpc_pkg::OFS_OUT))
      nxt_out = apply_acc(nxt_out, pb_kind, pb_wdata);
    if (hit(pb_wr, pb_base, gpc_pkg::OFS_DRV))
      nxt_drv = apply_acc(nxt_drv, pb_kind, pb_wdata);
    // Same clock as the bus, so the local path never drops a write
    if (hit(lb_wr, lb_base, gpc_pkg::OFS_OUT))
      nxt_out = apply_acc(nxt_out, lb_kind, lb_wdata);
    if (hit(lb_wr, lb_base, gpc_pkg::OFS_DRV))
      nxt_drv = apply_acc(nxt_drv, lb_kind, lb_wdata);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_ff <= gpc_pkg::RST_ZERO;
      drv_ff <= gpc_pkg::RST_ZERO;
    end
    else
    begin
      out_ff <= nxt_out;
      drv_ff <= nxt_drv;
    end
  end

  // Input synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_ff <= gpc_pkg::RST_ZERO;
      sync2_ff <= gpc_pkg::RST_ZERO;
    end
    else
    begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Level register; gated bits hold to save toggling power
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      level_ff <= gpc_pkg::RST_ZERO;
    else
    begin
      for (int i = 0; i < 32; i++)
      begin
        if (own_ff[i] || irqen_ff[i])
          level_ff[i] <= sync2_ff[i];
      end
    end
  end

  // Glitch filter: a new level is taken only once seen twice
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      filt_ff <= gpc_pkg::RST_ZERO;
      det_prev_ff <= gpc_pkg::RST_ZERO;
    end
    else
    begin
      for (int i = 0; i < 32; i++)
      begin
        if (sync2_ff[i] == level_cmp(i))
          filt_ff[i] <= sync2_ff[i];
      end
      det_prev_ff <= det;
    end
  end

  // Previous synchronised sample, used only by the filter
  logic [31:0] sync3_ff;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sync3_ff <= gpc_pkg::RST_ZERO;
    else
      sync3_ff <= sync2_ff;
  end

  function automatic logic level_cmp(input int idx);
    return sync3_ff[idx[4:0]];
  endfunction : level_cmp

  // Filter only touches the detection path, never level or peripherals
  assign det = (gfilt_ff & filt_ff) | (~gfilt_ff & sync2_ff);

  // Condition per pin; independent of ownership
  always_comb
  begin
    cond = '0;
    for (int i = 0; i < 32; i++)
    begin
      unique case ({mode1_ff[i], mode0_ff[i]})
        gpc_pkg::MODE_CHANGE: cond[i] = det[i] ^ det_prev_ff[i];
        gpc_pkg::MODE_RISE: cond[i] = det[i] & ~det_prev_ff[i];
        gpc_pkg::MODE_FALL: cond[i] = ~det[i] & det_prev_ff[i];
        default: cond[i] = 1'b0;
      endcase
    end
  end

  // Flags: write zero clears, set wins over a clear in the same cycle
  always_comb
  begin
    nxt_flags = flags_ff;
    if (hit(pb_wr, pb_base, gpc_pkg::OFS_FLAGS))
    begin
      if (pb_kind == gpc_pkg::ACC_WORD)
        nxt_flags = flags_ff & pb_wdata;
      else if (pb_kind == gpc_pkg::ACC_CLR)
        nxt_flags = flags_ff & ~pb_wdata;
    end
    nxt_flags = nxt_flags | (cond & irqen_ff);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flags_ff <= gpc_pkg::RST_ZERO;
    else
      flags_ff <= nxt_flags;
  end

  // Group OR of pending flags and of event triggers
  always_comb
  begin
    nxt_irq = '0;
    nxt_event = '0;
    for (int g = 0; g < 4; g++)
    begin
      nxt_irq[g] = |(flags_ff[g*8 +: 8] & irqen_ff[g*8 +: 8]);
      nxt_event[g] = |(cond[g*8 +: 8] & even_ff[g*8 +: 8]);
    end
  end

  // Request lines are flops, so they only move while the clock runs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_ff <= '0;
      event_ff <= '0;
    end
    else
    begin
      irq_ff <= nxt_irq;
      event_ff <= nxt_event;
    end
  end

  // Read path; unmapped or write-only addresses read zero
  always_comb
  begin
    nxt_rdata = '0;
    if (pb_addr[3:2] == gpc_pkg::ACC_WORD)
    begin
      unique case (pb_base)
        gpc_pkg::OFS_OWN: nxt_rdata = own_ff;
        gpc_pkg::OFS_FSEL0: nxt_rdata = fsel0_ff;
        gpc_pkg::OFS_FSEL1: nxt_rdata = fsel1_ff;
        gpc_pkg::OFS_DRV: nxt_rdata = drv_ff;
        gpc_pkg::OFS_OUT: nxt_rdata = out_ff;
        gpc_pkg::OFS_LEVEL: nxt_rdata = level_ff;
        gpc_pkg::OFS_PULL: nxt_rdata = pull_ff;
        gpc_pkg::OFS_IRQEN: nxt_rdata = irqen_ff;
        gpc_pkg::OFS_MODE0: nxt_rdata = mode0_ff;
        gpc_pkg::OFS_MODE1: nxt_rdata = mode1_ff;
        gpc_pkg::OFS_GFILT: nxt_rdata = gfilt_ff;
        gpc_pkg::OFS_FLAGS: nxt_rdata = flags_ff;
        gpc_pkg::OFS_EVEN: nxt_rdata = even_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= '0;
    else if (pb_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= '0;
  end

  // Pad mux stays combinational so peripherals keep the pin with clk off
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      logic [1:0] fn;
      fn = {fsel1_ff[i], fsel0_ff[i]};
      if (own_ff[i])
      begin
        pad_out[i] = out_ff[i];
        pad_oe[i] = drv_ff[i];
        pad_pullup[i] = pull_ff[i];
      end
      else
      begin
        pad_out[i] = fn_out[fn][i];
        pad_oe[i] = fn_oe[fn][i];
        pad_pullup[i] = fn_pull_ctl[fn][i] ? fn_pull[fn][i]
                                           : pull_ff[i];
      end
    end
  end

  assign pb_rdata = rdata_ff;
  assign irq_req = irq_ff;
  assign event_line = event_ff;

endmodule : gpc_port
`default_nettype wire

// ---- verilog/gpc_pkg.sv ----
// Package: register map, field layout and reset values of the pin controller
package gpc_pkg;
  localparam int unsigned PINS = 32;
  localparam int unsigned GROUP = 8;
  localparam int unsigned NGROUPS = 4;
  localparam int unsigned NFUNC = 4;
  localparam int unsigned AW = 10;
  // Register bases; low two address bits of the word index pick the access
  localparam logic [9:0] OFS_OWN = 10'h000;
  localparam logic [9:0] OFS_FSEL0 = 10'h010;
  localparam logic [9:0] OFS_FSEL1 = 10'h020;
  localparam logic [9:0] OFS_DRV = 10'h040;
  localparam logic [9:0] OFS_OUT = 10'h050;
  localparam logic [9:0] OFS_LEVEL = 10'h060;
  localparam logic [9:0] OFS_PULL = 10'h070;
  localparam logic [9:0] OFS_IRQEN = 10'h090;
  localparam logic [9:0] OFS_MODE0 = 10'h0A0;
  localparam logic [9:0] OFS_MODE1 = 10'h0B0;
  localparam logic [9:0] OFS_GFILT = 10'h0C0;
  localparam logic [9:0] OFS_FLAGS = 10'h0D0;
  localparam logic [9:0] OFS_EVEN = 10'h0E0;
  // Access kind at base + 4 * kind
  localparam logic [1:0] ACC_WORD = 2'h0;
  localparam logic [1:0] ACC_SET = 2'h1;
  localparam logic [1:0] ACC_CLR = 2'h2;
  localparam logic [1:0] ACC_TGL = 2'h3;
  // Interrupt mode encoding {mode1, mode0}
  localparam logic [1:0] MODE_CHANGE = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  // Reset values
  localparam logic [31:0] RST_OWN = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
endpackage : gpc_pkg

// ---- verilog/unused_placeholder_none.sv ----
// Intentionally empty file holding no design
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- testbench/gpc_sva.sv ----
// Checker on the pin controller port boundary
`timescale 1ns/1ns
`default_nettype none
module gpc_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Buses
  input wire logic [9:0] pb_addr,
  input wire logic [31:0] pb_wdata,
  input wire logic pb_wr,
  input wire logic pb_rd,
  input wire logic [31:0] pb_rdata,
  input wire logic lb_wr,
  // Pads and requests
  input wire logic [31:0] pad_in,
  input wire logic [31:0] pad_out,
  input wire logic [3:0] irq_req,
  input wire logic [3:0] event_line
);
  logic [31:0] own_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Ownership copy, so output checks skip peripheral pins
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      own_ff <= gpc_pkg::RST_OWN;
    else if (pb_wr && pb_addr[9:4] == gpc_pkg::OFS_OWN[9:4])
      case (pb_addr[3:2])
        gpc_pkg::ACC_WORD: own_ff <= pb_wdata;
        gpc_pkg::ACC_SET: own_ff <= own_ff | pb_wdata;
        gpc_pkg::ACC_CLR: own_ff <= own_ff & ~pb_wdata;
        default: own_ff <= own_ff ^ pb_wdata;
      endcase
  sequence s_wr_out;
    pb_wr && !lb_wr && pb_addr == gpc_pkg::OFS_OUT;
  endsequence
  sequence s_rd_out;
    pb_rd && !lb_wr && pb_addr == gpc_pkg::OFS_OUT;
  endsequence
  // Filter adds two stages, so the cause lies one of two lags back
  sequence s_moved;
    $past(pad_in[7:0], 3) != $past(pad_in[7:0], 4)
      || $past(pad_in[7:0], 5) != $past(pad_in[7:0], 6);
  endsequence
  sequence s_irq_cause;
    $past(pad_in[7:0], 4) != $past(pad_in[7:0], 5)
      || $past(pad_in[7:0], 6) != $past(pad_in[7:0], 7);
  endsequence
  property p_rd0;
    !$past(pb_rd) |-> pb_rdata == 32'h0;
  endproperty
  property p_unmap;
    pb_rd && pb_addr == 10'h3F0 |=> pb_rdata == 32'h0;
  endproperty
  property p_rdback;
    s_wr_out ##1 s_rd_out |=> pb_rdata == $past(pb_wdata, 2);
  endproperty
  property p_set;
    pb_wr && !lb_wr && pb_addr == (gpc_pkg::OFS_OUT | 10'h004) |=>
      (pad_out & own_ff & $past(pb_wdata)) == (own_ff & $past(pb_wdata));
  endproperty
  property p_clr;
    pb_wr && !lb_wr && pb_addr == (gpc_pkg::OFS_OUT | 10'h008) |=>
      (pad_out & own_ff & $past(pb_wdata)) == 32'h0;
  endproperty
  property p_evt;
    event_line[0] |-> s_moved;
  endproperty
  property p_irq;
    $rose(irq_req[0]) |-> s_irq_cause;
  endproperty
  property p_irqclr;
    pb_wr && pb_addr == gpc_pkg::OFS_FLAGS && pb_wdata[7:0] == 8'h00
      |=> ##1 !irq_req[0];
  endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_rdback: assert property (p_rdback) else $error("readback");
  a_set: assert property (p_set) else $error("set lost");
  a_clr: assert property (p_clr) else $error("clear lost");
  a_evt: assert property (p_evt) else $error("event no cause");
  a_irq: assert property (p_irq) else $error("irq no cause");
  a_irqclr: assert property (p_irqclr) else $error("irq kept");
endmodule : gpc_sva
bind gpc_port gpc_sva u_sva (.clk, .resetn, .pb_addr, .pb_wdata, .pb_wr,
  .pb_rd, .pb_rdata, .lb_wr, .pad_in, .pad_out, .irq_req, .event_line);
`default_nettype wire

// ---- testbench/gpc_pins.sv ----
// Model of the pads, outside drivers and peripheral functions
`timescale 1ns/1ns
`default_nettype none
module gpc_pins (
  // From the port
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  // Outside driver and peripheral pattern
  input wire logic [31:0] ext_val,
  input wire logic [31:0] fn_seed,
  // To the port
  output logic [31:0] pad_in,
  output logic [3:0][31:0] fn_out,
  output logic [3:0][31:0] fn_oe,
  output logic [3:0][31:0] fn_pull_ctl,
  output logic [3:0][31:0] fn_pull
);
  // Weak outside driver; port drive wins the pad
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
  // Distinct value per function so selection shows at the pad
  always_comb
    for (int f = 0; f < 4; f++)
    begin
      fn_out[f] = fn_seed * (2 * f + 1);
      fn_oe[f] = ~fn_seed;
      fn_pull_ctl[f] = 32'h0000FFFF;
      fn_pull[f] = fn_seed;
    end
endmodule : gpc_pins
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for one pin controller port
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pb_wr = 1'b0;
  logic pb_rd = 1'b0;
  logic lb_wr = 1'b0;
  logic [9:0] pb_addr = 10'h000;
  logic [9:0] lb_addr = 10'h000;
  logic [31:0] pb_wdata = 32'h0;
  logic [31:0] lb_wdata = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] fn_seed = 32'h0;
  logic [31:0] pb_rdata, pad_in, pad_out, pad_oe, pad_pullup, a, b, e, x;
  logic [3:0][31:0] fn_out, fn_oe, fn_pull_ctl, fn_pull;
  logic [3:0] irq_req, event_line;
  logic [3:0] ev_seen = 4'h0;
  logic rd_ff = 1'b0;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  int p;
  // One clock for both buses avoids lost local writes
  always #50 clk = ~clk;
  gpc_port uut (.clk, .resetn, .pb_addr, .pb_wdata, .pb_wr, .pb_rd,
    .pb_rdata, .lb_addr, .lb_wdata, .lb_wr, .pad_in, .pad_out, .pad_oe,
    .pad_pullup, .fn_out, .fn_oe, .fn_pull_ctl, .fn_pull, .irq_req,
    .event_line);
  gpc_pins u_pins (.pad_out, .pad_oe, .ext_val, .fn_seed, .pad_in, .fn_out,
    .fn_oe, .fn_pull_ctl, .fn_pull);
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic r, input logic [9:0] ad,
      input logic [31:0] d);
    pb_wr <= w;
    pb_rd <= r;
    pb_addr <= ad;
    pb_wdata <= d;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [9:0] ad, input logic [31:0] d);
    bus(1'b1, 1'b0, ad, d);
  endtask : wr
  task automatic rd(input logic [9:0] ad, input logic [31:0] want);
    exp_q.push_back(want);
    bus(1'b0, 1'b1, ad, 32'h0);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 10'h000, 32'h0);
  endtask : idle
  task automatic print_verdict;
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
    rd_ff <= pb_rd;
  always @(negedge clk)
    if (rd_ff)
      check("pb_rdata", pb_rdata, exp_q.pop_front());
  // Events are single pulses; keep a sticky record per group
  // Cleared in reset: the design's flops are unknown before the first edge
  always @(posedge clk)
    if (!resetn)
      ev_seen <= 4'h0;
    else
      ev_seen <= ev_seen | event_line;
  initial
  begin
    #(100 * 5000);
    err_total++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'hA8623CC9));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 15; i++)
      rd(10'(i * 16), i == 0 ? gpc_pkg::RST_OWN : gpc_pkg::RST_ZERO);
    rd(10'h3F0, 32'h0);
    wr(gpc_pkg::OFS_DRV, 32'hFFFFFFFF);
    e = $urandom;
    wr(gpc_pkg::OFS_OUT, e);
    rd(gpc_pkg::OFS_OUT, e);
    for (int k = 1; k < 4; k++)
    begin
      a = $urandom;
      wr(gpc_pkg::OFS_OUT | 10'(k * 4), a);
      e = k == 1 ? e | a : k == 2 ? e & ~a : e ^ a;
      idle(1);
      check("pad_out", pad_out, e);
    end
    lb_addr <= gpc_pkg::OFS_DRV | 10'h008;
    lb_wdata <= 32'h000000FF;
    lb_wr <= 1'b1;
    idle(1);
    lb_wr <= 1'b0;
    idle(1);
    check("pad_oe", pad_oe, 32'hFFFFFF00);
    b = $urandom;
    wr(gpc_pkg::OFS_DRV, 32'h0);
    ext_val <= b;
    idle(4);
    rd(gpc_pkg::OFS_LEVEL, b);
    wr(gpc_pkg::OFS_OWN, 32'h0);
    ext_val <= ~b;
    idle(4);
    rd(gpc_pkg::OFS_LEVEL, b);
    fn_seed <= $urandom;
    a = $urandom;
    b = $urandom;
    e = $urandom;
    wr(gpc_pkg::OFS_FSEL0, a);
    wr(gpc_pkg::OFS_FSEL1, b);
    wr(gpc_pkg::OFS_PULL, e);
    idle(1);
    for (int i = 0; i < 32; i++)
      x[i] = fn_out[{b[i], a[i]}][i];
    check("pad_out", pad_out, x);
    check("pad_oe", pad_oe, ~fn_seed);
    x = (fn_seed & 32'h0000FFFF) | (e & 32'hFFFF0000);
    check("pad_pullup", pad_pullup, x);
    fn_seed <= 32'hFFFFFFFF;
    ext_val <= 32'h0;
    idle(6);
    for (int m = 0; m < 4; m++)
    begin
      p = 8 * m + 1;
      wr(gpc_pkg::OFS_IRQEN, 32'h1 << p);
      wr(gpc_pkg::OFS_EVEN, 32'h1 << p);
      wr(gpc_pkg::OFS_MODE0, {32{m[0]}});
      wr(gpc_pkg::OFS_MODE1, {32{m[1]}});
      ext_val[p] <= 1'b1;
      idle(6);
      rd(gpc_pkg::OFS_FLAGS, m < 2 ? 32'h1 << p : 32'h0);
      ext_val[p] <= 1'b0;
      idle(6);
      x = m < 3 ? 32'h1 << m : 32'h0;
      check("irq_req", 32'(irq_req), x);
      wr(gpc_pkg::OFS_FLAGS, 32'h0);
      idle(2);
      check("irq_req", 32'(irq_req), 32'h0);
      rd(gpc_pkg::OFS_FLAGS, 32'h0);
    end
    idle(2);
    check("event_line", 32'(ev_seen), 32'h7);
    // Filter on pin 1: a one-cycle pulse is dropped, a held level is taken
    wr(gpc_pkg::OFS_IRQEN, 32'h00000002);
    wr(gpc_pkg::OFS_MODE0, 32'h00000000);
    wr(gpc_pkg::OFS_MODE1, 32'h00000000);
    wr(gpc_pkg::OFS_GFILT, 32'h00000002);
    ext_val[1] <= 1'b1;
    idle(1);
    ext_val[1] <= 1'b0;
    idle(6);
    rd(gpc_pkg::OFS_FLAGS, 32'h00000000);
    ext_val[1] <= 1'b1;
    idle(8);
    rd(gpc_pkg::OFS_FLAGS, 32'h00000002);
    idle(2);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
